// ---- rtl/sampler_fe_pkg.sv ----
// constants for the sampler message front end
package sampler_fe_pkg;
    // command header fields
    localparam int unsigned SUBOP_HI        = 23;
    localparam int unsigned SUBOP_LO        = 16;
    localparam int unsigned LEN_HI          = 7;
    localparam logic [7:0]  SUBOP_PALETTE   = 8'h02;
    localparam logic [7:0]  SUBOP_MONO_SIZE = 8'h11;
    localparam int unsigned PALETTE_DEPTH   = 256;
    // palette dword fields
    localparam int unsigned PAL_A_LO        = 24;
    localparam int unsigned PAL_R_LO        = 16;
    localparam int unsigned PAL_G_LO        = 8;
    localparam int unsigned PAL_B_LO        = 0;
    // mono filter size fields
    localparam int unsigned MONO_W_LO       = 3;
    localparam int unsigned MONO_H_LO       = 0;
    localparam logic [2:0]  MONO_W_MIN      = 3'h1;
    // message descriptor fields
    localparam int unsigned DESC_HDR_BIT    = 19;
    localparam int unsigned DESC_SIMD_LO    = 17;
    localparam int unsigned DESC_TYPE_LO    = 12;
    localparam int unsigned DESC_SIDX_LO    = 8;
    localparam int unsigned DESC_BTI_LO     = 0;
    // message header fields (dword 2 and dword 3)
    localparam int unsigned HDR_SPTR_LO     = 5;
    localparam int unsigned HDR_GCH_LO      = 16;
    localparam int unsigned HDR_FLOD_BIT    = 16;
    localparam int unsigned HDR_MASK_LO     = 12;
    // simd modes
    localparam logic [1:0]  SIMD_4X2        = 2'h0;
    localparam logic [1:0]  SIMD_8          = 2'h1;
    localparam logic [1:0]  SIMD_16         = 2'h2;
    localparam logic [1:0]  SIMD_32         = 2'h3;
    // message types
    localparam logic [4:0]  MT_LD           = 5'h07;
    localparam logic [4:0]  MT_FOUR_TEXEL_GATHER_MESSAGE      = 5'h08;
    localparam logic [4:0]  MT_RESINFO      = 5'h0a;
    localparam logic [4:0]  MT_SAMPLEINFO   = 5'h0b;
    localparam logic [4:0]  MT_FOUR_TEXEL_GATHER_MESSAGE_C    = 5'h10;
    localparam logic [4:0]  MT_FOUR_TEXEL_GATHER_MESSAGE_PO   = 5'h11;
    localparam logic [4:0]  MT_FOUR_TEXEL_GATHER_MESSAGE_POC  = 5'h12;
    localparam logic [4:0]  MT_CACHE_FLUSH  = 5'h1f;
    localparam logic [4:0]  MT_UNORM_PS     = 5'h00;
    localparam logic [4:0]  MT_UNORM_KP_PS  = 5'h02;
    localparam logic [4:0]  MT_SCALE_PS     = 5'h03;
    localparam logic [4:0]  MT_DEINTERLACE  = 5'h08;
    localparam logic [4:0]  MT_UNORM_MD     = 5'h0c;
    localparam logic [4:0]  MT_UNORM_KP_MD  = 5'h0a;
    localparam logic [4:0]  MT_SCALE_MD     = 5'h0b;
endpackage : sampler_fe_pkg

// ---- rtl/sampler_fe_if.sv ----
// link between the issuing thread side and the sampler front end
`timescale 1ns/10ps
`default_nettype none
interface sampler_fe_if;
    // state command stream
    logic        cmd_valid;
    logic        cmd_first;
    logic [31:0] cmd_data;
    // request message
    logic        msg_valid;
    logic        msg_ready;
    logic [31:0] msg_desc;
    logic        msg_eot;
    logic [15:0] msg_exec_mask;
    logic [4:0]  msg_rlen;
    logic [31:0] msg_hdr2;
    logic [31:0] msg_hdr3;

    modport device (
        input  cmd_valid, cmd_first, cmd_data,
        input  msg_valid, msg_desc, msg_eot, msg_exec_mask, msg_rlen,
        input  msg_hdr2, msg_hdr3,
        output msg_ready
    );
    modport thread (
        output cmd_valid, cmd_first, cmd_data,
        output msg_valid, msg_desc, msg_eot, msg_exec_mask, msg_rlen,
        output msg_hdr2, msg_hdr3,
        input  msg_ready
    );
endinterface : sampler_fe_if
`default_nettype wire

// ---- rtl/sampler_fe_thread.sv ----
// issuing end: drives state commands and request messages
`timescale 1ns/10ps
`default_nettype none
module sampler_fe_thread
    import sampler_fe_pkg::*;
(
    // clock and reset
    input  wire logic        sys_clk_i,
    input  wire logic        resetn_i,
    // command request
    input  wire logic        cmd_valid_i,
    input  wire logic        cmd_first_i,
    input  wire logic [31:0] cmd_data_i,
    // message request
    input  wire logic        msg_valid_i,
    input  wire logic        hdr_present_i,
    input  wire logic [1:0]  simd_i,
    input  wire logic [4:0]  mtype_i,
    input  wire logic [3:0]  sampler_idx_i,
    input  wire logic [7:0]  bti_i,
    input  wire logic [15:0] exec_mask_i,
    input  wire logic [4:0]  rlen_i,
    input  wire logic [31:0] hdr2_i,
    input  wire logic [31:0] hdr3_i,
    output logic             msg_busy_o,
    output logic             msg_sent_o,
    // link
    sampler_fe_if.thread     lnk
);
    // ************************************************
    // sender side encoding
    // ************************************************
    function automatic logic is_gather_c(input logic [4:0] t);
        return (t == MT_FOUR_TEXEL_GATHER_MESSAGE_C) || (t == MT_FOUR_TEXEL_GATHER_MESSAGE_POC);
    endfunction

    logic [3:0]  sidx_fix;
    logic [31:0] hdr2_fix;
    logic [31:0] desc;
    logic        hold_q;

    always_comb begin
        sidx_fix = sampler_idx_i;
        hdr2_fix = hdr2_i;
        if (simd_i == SIMD_32 && mtype_i == MT_DEINTERLACE) begin
            sidx_fix[0] = 1'b0;
        end
        if (simd_i == SIMD_32 &&
            (mtype_i == MT_SCALE_PS || mtype_i == MT_SCALE_MD)) begin
            sidx_fix[1:0] = 2'h0;
        end
        if (simd_i != SIMD_32 && is_gather_c(mtype_i)) begin
            hdr2_fix[HDR_GCH_LO +: 2] = 2'h0;
        end
        if (&hdr2_fix[HDR_MASK_LO +: 4]) begin
            hdr2_fix[HDR_MASK_LO] = 1'b0;
        end
        desc = '0;
        desc[DESC_HDR_BIT]      = hdr_present_i;
        desc[DESC_SIMD_LO +: 2] = simd_i;
        desc[DESC_TYPE_LO +: 5] = mtype_i;
        desc[DESC_SIDX_LO +: 4] = sidx_fix;
        desc[DESC_BTI_LO +: 8]  = bti_i;
    end

    // ************************************************
    // link drive
    // ************************************************
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            lnk.cmd_valid <= 1'b0;
            lnk.cmd_first <= 1'b0;
            lnk.cmd_data  <= '0;
        end else begin
            lnk.cmd_valid <= cmd_valid_i;
            lnk.cmd_first <= cmd_first_i;
            lnk.cmd_data  <= cmd_data_i;
        end
    end

    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            hold_q            <= 1'b0;
            lnk.msg_valid     <= 1'b0;
            lnk.msg_desc      <= '0;
            lnk.msg_eot       <= 1'b0;
            lnk.msg_exec_mask <= '0;
            lnk.msg_rlen      <= '0;
            lnk.msg_hdr2      <= '0;
            lnk.msg_hdr3      <= '0;
            msg_sent_o        <= 1'b0;
        end else begin
            msg_sent_o <= hold_q && lnk.msg_ready;
            if (hold_q && lnk.msg_ready) begin
                hold_q        <= 1'b0;
                lnk.msg_valid <= 1'b0;
            end else if (!hold_q && msg_valid_i) begin
                hold_q            <= 1'b1;
                lnk.msg_valid     <= 1'b1;
                lnk.msg_desc      <= desc;
                lnk.msg_eot       <= 1'b0;
                lnk.msg_exec_mask <= exec_mask_i;
                lnk.msg_rlen      <= rlen_i;
                lnk.msg_hdr2      <= hdr2_fix;
                lnk.msg_hdr3      <= hdr3_i;
            end
        end
    end

    assign msg_busy_o = hold_q;
endmodule : sampler_fe_thread
`default_nettype wire

// ---- rtl/sampler_fe_device.sv ----
// sampler front end: state command decode and message decode
//
`timescale 1ns/10ps
`default_nettype none
module sampler_fe_device
    import sampler_fe_pkg::*;
#(
    parameter int unsigned DEPTH = PALETTE_DEPTH
)(
    // clock and reset
    input  wire logic        sys_clk_i,
    input  wire logic        resetn_i,
    // filter mode from sampler state
    input  wire logic        mono_mode_i,
    // palette read port
    input  wire logic [7:0]  pal_raddr_i,
    output logic [31:0]      pal_rdata_o,
    output logic [8:0]       pal_count_o,
    // monochrome filter size
    output logic [2:0]       mono_width_o,
    output logic [2:0]       mono_height_o,
    // decoded message to the pipeline
    output logic             req_valid_o,
    output logic [1:0]       req_simd_o,
    output logic [4:0]       req_type_o,
    output logic [3:0]       req_sampler_o,
    output logic [7:0]       req_bti_o,
    output logic [15:0]      req_pix_valid_o,
    output logic [15:0]      req_lod_valid_o,
    output logic [3:0]       req_chan_en_o,
    output logic [1:0]       req_gather_ch_o,
    output logic             req_force_lod0_o,
    output logic [26:0]      req_state_ptr_o,
    output logic             req_use_sampler_o,
    output logic             req_use_bti_o,
    output logic             req_mem_write_o,
    output logic             req_full16_o,
    output logic             req_eot_err_o,
    // link
    sampler_fe_if.device     lnk
);
    // ************************************************
    // state command decode
    // ************************************************
    typedef enum logic [2:0] {
        CMD_IDLE = 3'b001,
        CMD_PAL  = 3'b010,
        CMD_MONO = 3'b100
    } cmd_state_e;

    cmd_state_e  cmd_q;
    logic [7:0]  left_q;
    logic [7:0]  pal_idx_q;
    logic [31:0] palette [DEPTH];
    logic [7:0]  pal_a;
    logic [7:0]  pal_r;
    logic [7:0]  pal_g;
    logic [7:0]  pal_b;
    logic        pal_we;

    assign pal_a = lnk.cmd_data[PAL_A_LO +: 8];
    assign pal_r = lnk.cmd_data[PAL_R_LO +: 8];
    assign pal_g = lnk.cmd_data[PAL_G_LO +: 8];
    assign pal_b = lnk.cmd_data[PAL_B_LO +: 8];
    assign pal_we = lnk.cmd_valid && !lnk.cmd_first && cmd_q == CMD_PAL;

    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cmd_q     <= CMD_IDLE;
            left_q    <= '0;
            pal_idx_q <= '0;
        end else if (lnk.cmd_valid && lnk.cmd_first) begin
            // reserved bits 15:8 are not checked
            left_q    <= lnk.cmd_data[LEN_HI:0];
            pal_idx_q <= '0;
            case (lnk.cmd_data[SUBOP_HI:SUBOP_LO])
                SUBOP_PALETTE:   cmd_q <= CMD_PAL;
                SUBOP_MONO_SIZE: cmd_q <= CMD_MONO;
                default:         cmd_q <= CMD_IDLE;
            endcase
        end else if (lnk.cmd_valid) begin
            case (cmd_q)
                CMD_PAL: begin
                    pal_idx_q <= pal_idx_q + 8'h01;
                    left_q    <= left_q - 8'h01;
                    if (left_q == 8'h00) begin
                        cmd_q <= CMD_IDLE;
                    end
                end
                CMD_MONO: cmd_q <= CMD_IDLE;
                CMD_IDLE: cmd_q <= CMD_IDLE;
                default:  cmd_q <= CMD_IDLE;
            endcase
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (pal_we) begin
            palette[pal_idx_q] <= {pal_a, pal_r, pal_g, pal_b};
        end
    end

    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pal_rdata_o <= '0;
            pal_count_o <= '0;
        end else begin
            pal_rdata_o <= palette[pal_raddr_i];
            if (lnk.cmd_valid && lnk.cmd_first &&
                lnk.cmd_data[SUBOP_HI:SUBOP_LO] == SUBOP_PALETTE) begin
                pal_count_o <= '0;
            end else if (pal_we) begin
                pal_count_o <= {1'b0, pal_idx_q} + 9'h001;
            end
        end
    end

    logic [2:0] mono_w_q;
    logic [2:0] mono_h_q;

    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            mono_w_q <= MONO_W_MIN;
            mono_h_q <= '0;
        end else if (lnk.cmd_valid && !lnk.cmd_first && cmd_q == CMD_MONO) begin
            // bits 31:6 reserved, ignored
            if (lnk.cmd_data[MONO_W_LO +: 3] >= MONO_W_MIN) begin
                mono_w_q <= lnk.cmd_data[MONO_W_LO +: 3];
            end
            mono_h_q <= lnk.cmd_data[MONO_H_LO +: 3];
        end
    end

    assign mono_width_o  = mono_mode_i ? mono_w_q : 3'h0;
    assign mono_height_o = mono_mode_i ? mono_h_q : 3'h0;

    // ************************************************
    // message decode
    // ************************************************
    function automatic logic [15:0] lod_expand(input logic [15:0] m);
        logic [15:0] r;
        r = m;
        for (int s = 0; s < 4; s++) begin
            if (|m[s*4 +: 4]) begin
                r[s*4 +: 3] = 3'h7;
            end
        end
        return r;
    endfunction

    logic        hdr_on;
    logic [1:0]  simd;
    logic [4:0]  mtype;
    logic [31:0] h2;
    logic [31:0] h3;
    logic        no_sidx;
    logic        gather;
    logic        scaling;
    logic        chan_fixed;
    logic [15:0] pix_v;
    logic [15:0] lod_v;
    logic [3:0]  chan;

    always_comb begin
        hdr_on = lnk.msg_desc[DESC_HDR_BIT];
        simd   = lnk.msg_desc[DESC_SIMD_LO +: 2];
        mtype  = lnk.msg_desc[DESC_TYPE_LO +: 5];
        h2     = hdr_on ? lnk.msg_hdr2 : 32'h0;
        h3     = hdr_on ? lnk.msg_hdr3 : 32'h0;
        no_sidx = simd != SIMD_32 &&
                  (mtype == MT_LD || mtype == MT_RESINFO ||
                   mtype == MT_SAMPLEINFO);
        if (simd == SIMD_32 && mtype == MT_CACHE_FLUSH) begin
            no_sidx = 1'b1;
        end
        gather = simd != SIMD_32 &&
                 (mtype == MT_FOUR_TEXEL_GATHER_MESSAGE || mtype == MT_FOUR_TEXEL_GATHER_MESSAGE_C ||
                  mtype == MT_FOUR_TEXEL_GATHER_MESSAGE_PO || mtype == MT_FOUR_TEXEL_GATHER_MESSAGE_POC);
        scaling = simd == SIMD_32 &&
                  (mtype == MT_SCALE_PS || mtype == MT_SCALE_MD);
        chan_fixed = simd == SIMD_32 &&
                     (mtype == MT_UNORM_PS || mtype == MT_UNORM_KP_PS ||
                      mtype == MT_UNORM_MD || mtype == MT_UNORM_KP_MD ||
                      mtype == MT_DEINTERLACE);
        chan = ~h2[HDR_MASK_LO +: 4];
        pix_v = '0;
        lod_v = '0;
        case (simd)
            SIMD_16: begin
                pix_v = lnk.msg_exec_mask;
                lod_v = lod_expand(pix_v);
            end
            SIMD_8: begin
                pix_v = {8'h00, lnk.msg_exec_mask[7:0]};
                lod_v = lod_expand(pix_v);
            end
            SIMD_4X2: begin
                pix_v[0] = |lnk.msg_exec_mask[3:0];
                pix_v[1] = |lnk.msg_exec_mask[7:4];
                lod_v    = pix_v;
            end
            SIMD_32: begin
                pix_v = 16'hffff;
                lod_v = 16'hffff;
                chan  = 4'hf;
            end
            default: begin
                pix_v = '0;
            end
        endcase
        if (chan_fixed) begin
            chan = 4'hf;
        end
    end

    assign lnk.msg_ready = 1'b1;

    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            req_valid_o       <= 1'b0;
            req_simd_o        <= '0;
            req_type_o        <= '0;
            req_sampler_o     <= '0;
            req_bti_o         <= '0;
            req_pix_valid_o   <= '0;
            req_lod_valid_o   <= '0;
            req_chan_en_o     <= '0;
            req_gather_ch_o   <= '0;
            req_force_lod0_o  <= 1'b0;
            req_state_ptr_o   <= '0;
            req_use_sampler_o <= 1'b0;
            req_use_bti_o     <= 1'b0;
            req_mem_write_o   <= 1'b0;
            req_full16_o      <= 1'b0;
            req_eot_err_o     <= 1'b0;
        end else begin
            req_valid_o   <= lnk.msg_valid;
            req_eot_err_o <= lnk.msg_valid && lnk.msg_eot;
            if (lnk.msg_valid) begin
                req_simd_o      <= simd;
                req_type_o      <= mtype;
                req_sampler_o   <= no_sidx ? 4'h0
                                 : lnk.msg_desc[DESC_SIDX_LO +: 4];
                req_use_sampler_o <= !no_sidx;
                req_use_bti_o   <= !(simd == SIMD_32 &&
                                     mtype == MT_CACHE_FLUSH);
                req_bti_o       <= lnk.msg_desc[DESC_BTI_LO +: 8];
                req_pix_valid_o <= pix_v;
                req_lod_valid_o <= lod_v;
                req_chan_en_o   <= chan;
                req_gather_ch_o <= gather ? h2[HDR_GCH_LO +: 2] : 2'h0;
                req_force_lod0_o <= h3[HDR_FLOD_BIT];
                req_state_ptr_o <= (simd != SIMD_32 &&
                                    (mtype == MT_LD || mtype == MT_RESINFO))
                                 ? 27'h0 : h3[31:HDR_SPTR_LO];
                req_mem_write_o <= scaling && lnk.msg_rlen == 5'h00;
                req_full16_o    <= 1'b1;
            end
        end
    end
endmodule : sampler_fe_device
`default_nettype wire

// ---- tb/sampler_fe_monitor.sv ----
// link checker for the sampler front end pair
`timescale 1ns/10ps
`default_nettype none
module sampler_fe_monitor
    import sampler_fe_pkg::*;
(
    // clock and reset
    input  wire logic        sys_clk_i,
    input  wire logic        resetn_i,
    // link signals
    input  wire logic        cmd_valid,
    input  wire logic        cmd_first,
    input  wire logic [31:0] cmd_data,
    input  wire logic        msg_valid,
    input  wire logic        msg_ready,
    input  wire logic [31:0] msg_desc,
    input  wire logic        msg_eot,
    input  wire logic [15:0] msg_exec_mask,
    input  wire logic [4:0]  msg_rlen,
    input  wire logic [31:0] msg_hdr2,
    input  wire logic [31:0] msg_hdr3
);
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!resetn_i);

    logic [1:0] simd;
    logic [4:0] mtype;
    assign simd  = msg_desc[18:17];
    assign mtype = msg_desc[16:12];

    // ****************************************
    // sender and receiver side checks
    // ****************************************
    eot_clear_a:
    assert property (msg_valid |-> !msg_eot)
        else $error("request carries thread end flag");
    deint_even_a:
    assert property (msg_valid && simd == SIMD_32 && mtype == MT_DEINTERLACE
        |-> !msg_desc[8])
        else $error("deinterlace sampler index odd");
    scale_quad_a:
    assert property (msg_valid && simd == SIMD_32
        && (mtype == MT_SCALE_PS || mtype == MT_SCALE_MD)
        |-> msg_desc[9:8] == 2'h0)
        else $error("scaling sampler index not multiple of four");
    gather_red_a:
    assert property (msg_valid && msg_desc[19] && simd != SIMD_32
        && (mtype == MT_FOUR_TEXEL_GATHER_MESSAGE_C || mtype == MT_FOUR_TEXEL_GATHER_MESSAGE_POC)
        |-> msg_hdr2[17:16] == 2'h0)
        else $error("compare gather channel not red");
    chan_open_a:
    assert property (msg_valid && msg_desc[19] && simd != SIMD_32
        |-> msg_hdr2[15:12] != 4'hf)
        else $error("all four channels masked");
    ready_high_a:
    assert property (msg_valid |-> msg_ready)
        else $error("request not accepted");
    valid_pulse_a:
    assert property ($rose(msg_valid) |=> $fell(msg_valid))
        else $error("request valid longer than one cycle");
    first_framed_a:
    assert property (cmd_first |-> cmd_valid)
        else $error("command opcode dword without valid");
endmodule // sampler_fe_monitor
`default_nettype wire

// ---- tb/tb.sv ----
// testbench for the sampler front end pair
`timescale 1ns/10ps
`default_nettype none
module tb
    import sampler_fe_pkg::*;
;
    logic        sys_clk, resetn, mono_mode, cmd_valid, cmd_first;
    logic        msg_valid, hdr_present, msg_busy, req_valid, msg_sent;
    logic        req_flod, req_usmp, req_ubti, req_mem, req_f16, req_eot;
    logic [1:0]  simd, req_simd, req_gch;
    logic [2:0]  mono_w, mono_h;
    logic [3:0]  sidx, req_smp, req_chan;
    logic [4:0]  mtype, rlen, req_type;
    logic [7:0]  bti, pal_raddr, req_bti;
    logic [8:0]  pal_count;
    logic [15:0] emask, req_pix, req_lod;
    logic [26:0] req_sptr;
    logic [31:0] cmd_data, hdr2, hdr3, pal_rdata;
    int          miscompares, num_checks;
    int          cycles = 0;

    sampler_fe_if lnk_if ();
    sampler_fe_thread u_sampler_fe_thread (
        .sys_clk_i(sys_clk), .resetn_i(resetn), .cmd_valid_i(cmd_valid),
        .cmd_first_i(cmd_first), .cmd_data_i(cmd_data),
        .msg_valid_i(msg_valid), .hdr_present_i(hdr_present),
        .simd_i(simd), .mtype_i(mtype), .sampler_idx_i(sidx),
        .bti_i(bti), .exec_mask_i(emask), .rlen_i(rlen), .hdr2_i(hdr2),
        .hdr3_i(hdr3), .msg_busy_o(msg_busy), .msg_sent_o(msg_sent),
        .lnk(lnk_if));
    sampler_fe_device u_sampler_fe_device (
        .sys_clk_i(sys_clk), .resetn_i(resetn), .mono_mode_i(mono_mode),
        .pal_raddr_i(pal_raddr), .pal_rdata_o(pal_rdata),
        .pal_count_o(pal_count), .mono_width_o(mono_w),
        .mono_height_o(mono_h), .req_valid_o(req_valid),
        .req_simd_o(req_simd), .req_type_o(req_type),
        .req_sampler_o(req_smp), .req_bti_o(req_bti),
        .req_pix_valid_o(req_pix), .req_lod_valid_o(req_lod),
        .req_chan_en_o(req_chan), .req_gather_ch_o(req_gch),
        .req_force_lod0_o(req_flod), .req_state_ptr_o(req_sptr),
        .req_use_sampler_o(req_usmp), .req_use_bti_o(req_ubti),
        .req_mem_write_o(req_mem), .req_full16_o(req_f16),
        .req_eot_err_o(req_eot), .lnk(lnk_if));
    sampler_fe_monitor u_sampler_fe_monitor (
        .sys_clk_i(sys_clk), .resetn_i(resetn),
        .cmd_valid(lnk_if.cmd_valid), .cmd_first(lnk_if.cmd_first),
        .cmd_data(lnk_if.cmd_data), .msg_valid(lnk_if.msg_valid),
        .msg_ready(lnk_if.msg_ready), .msg_desc(lnk_if.msg_desc),
        .msg_eot(lnk_if.msg_eot), .msg_exec_mask(lnk_if.msg_exec_mask),
        .msg_rlen(lnk_if.msg_rlen), .msg_hdr2(lnk_if.msg_hdr2),
        .msg_hdr3(lnk_if.msg_hdr3));

    // ****************************************
    // tasks
    // ****************************************
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic cmd(input logic f, input logic [31:0] d);
        @(posedge sys_clk);
        cmd_valid <= 1'h1;
        cmd_first <= f;
        cmd_data  <= d;
    endtask

    task automatic cmd_end();
        @(posedge sys_clk);
        cmd_valid <= 1'h0;
        cmd_first <= 1'h0;
        repeat (4) @(posedge sys_clk);
    endtask

    task automatic pal_chk(input logic [7:0] a, input logic [31:0] e);
        @(posedge sys_clk);
        pal_raddr <= a;
        @(posedge sys_clk);
        @(negedge sys_clk);
        chk("palette entry", e, pal_rdata);
    endtask

    task automatic mono(input logic [31:0] h0, input logic [31:0] d,
                        input logic [2:0] w, input logic [2:0] h);
        cmd(1'h1, h0);
        cmd(1'h0, d);
        cmd_end();
        chk("mono width", w, mono_w);
        chk("mono height", h, mono_h);
    endtask

    task automatic send(input logic h, input logic [1:0] s,
                        input logic [4:0] t, input logic [3:0] si,
                        input logic [15:0] m, input logic [31:0] h2,
                        input logic [31:0] h3, input logic [4:0] r);
        int n;
        @(negedge sys_clk);
        while (msg_busy !== 1'h0)
            @(negedge sys_clk);
        @(posedge sys_clk);
        {hdr_present, simd, mtype, sidx, emask} <= {h, s, t, si, m};
        {hdr2, hdr3, rlen} <= {h2, h3, r};
        bti       <= bti + 8'h25;
        msg_valid <= 1'h1;
        @(posedge sys_clk);
        msg_valid <= 1'h0;
        n = 0;
        @(negedge sys_clk);
        while (req_valid !== 1'h1 && n < 8) begin
            @(negedge sys_clk);
            n++;
        end
        chk("request valid", 1'h1, req_valid);
        chk("message sent", 1'h1, msg_sent);
        chk("simd", s, req_simd);
        chk("type", t, req_type);
        chk("binding", bti, req_bti);
        chk("full16", 1'h1, req_f16);
        chk("eot error", 1'h0, req_eot);
    endtask

    initial begin
        sys_clk = 1'h0;
        forever #5 sys_clk = ~sys_clk;
    end

    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 5000) begin
            miscompares++;
            final_report();
        end
    end

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        {resetn, mono_mode, cmd_valid, cmd_first, msg_valid} = '0;
        {hdr_present, simd, mtype, sidx, bti, emask} = '0;
        {rlen, hdr2, hdr3, cmd_data, pal_raddr} = '0;
        miscompares = 0;
        num_checks = 0;
        repeat (12) @(posedge sys_clk);
        resetn <= 1'h1;
        cmd(1'h1, 32'h7902_00ff);
        for (int i = 0; i < 256; i++)
            cmd(1'h0, {i[7:0], ~i[7:0], 8'h5a, 8'h3c});
        cmd_end();
        chk("palette count", 9'h100, pal_count);
        pal_chk(8'hff, 32'hff00_5a3c);
        cmd(1'h1, 32'h7902_0002);
        cmd(1'h0, 32'h1122_3344);
        cmd(1'h0, 32'haabb_ccdd);
        cmd(1'h0, 32'h00ff_80ff);
        cmd_end();
        chk("palette count", 9'h003, pal_count);
        pal_chk(8'h00, 32'h1122_3344);
        pal_chk(8'h02, 32'h00ff_80ff);
        pal_chk(8'h03, 32'h03fc_5a3c);
        mono_mode <= 1'h1;
        mono(32'h7911_0000, 32'h0000_002b, 3'h5, 3'h3);
        mono(32'h7911_0000, 32'hffff_ffff, 3'h7, 3'h7);
        mono_mode <= 1'h0;
        mono(32'h7904_0000, 32'h0000_0009, 3'h0, 3'h0);
        mono_mode <= 1'h1;
        mono(32'h7904_0000, 32'h0000_0009, 3'h7, 3'h7);
        send(1'h1, SIMD_16, 5'h00, 4'h3, 16'h8100, '0, '0, 5'h08);
        chk("pix valid", 16'h8100, req_pix);
        chk("lod valid", 16'hf700, req_lod);
        send(1'h0, SIMD_8, 5'h00, 4'h5, 16'hff81, 32'h0003_f000, '1, 5'h4);
        chk("pix valid", 16'h0081, req_pix);
        chk("lod valid", 16'h00f7, req_lod);
        chk("chan enable", 4'hf, req_chan);
        chk("state ptr", 27'h0, req_sptr);
        chk("force lod", 1'h0, req_flod);
        chk("sampler", 4'h5, req_smp);
        send(1'h1, SIMD_4X2, MT_LD, 4'h9, 16'h0010, 32'h5000, 32'hdeadbeef,
             5'h1);
        chk("pix valid", 16'h0002, req_pix);
        chk("chan enable", 4'ha, req_chan);
        chk("state ptr", 27'h0, req_sptr);
        chk("force lod", 1'h1, req_flod);
        chk("use bti", 1'h1, req_ubti);
        chk("use sampler", 1'h0, req_usmp);
        send(1'h1, SIMD_32, MT_UNORM_PS, 4'h2, 16'h0, 32'h3000, '0, 5'h8);
        chk("pix valid", 16'hffff, req_pix);
        chk("chan enable", 4'hf, req_chan);
        chk("use sampler", 1'h1, req_usmp);
        send(1'h1, SIMD_8, 5'h00, 4'h1, 16'h00ff, 32'hf000, 32'hdeadbeef,
             5'h4);
        chk("chan enable", 4'h1, req_chan);
        chk("state ptr", 32'hdeadbeef >> 5, req_sptr);
        for (int c = 0; c < 4; c++) begin
            send(1'h1, SIMD_8, MT_FOUR_TEXEL_GATHER_MESSAGE, 4'h1, 16'hff, c << 16, '0, 5'h4);
            chk("gather ch", c[1:0], req_gch);
        end
        send(1'h1, SIMD_8, MT_FOUR_TEXEL_GATHER_MESSAGE_C, 4'h1, 16'hff, 32'h30000, '0, 5'h4);
        chk("gather ch", 2'h0, req_gch);
        send(1'h1, SIMD_32, MT_DEINTERLACE, 4'h7, 16'h0, '0, '0, 5'h4);
        chk("sampler", 4'h6, req_smp);
        send(1'h1, SIMD_32, MT_SCALE_PS, 4'h7, 16'h0, '0, '0, 5'h0);
        chk("sampler", 4'h4, req_smp);
        chk("mem write", 1'h1, req_mem);
        send(1'h1, SIMD_32, MT_SCALE_MD, 4'h4, 16'h0, '0, '0, 5'h10);
        chk("mem write", 1'h0, req_mem);
        send(1'h0, SIMD_32, MT_CACHE_FLUSH, 4'h3, 16'h0, '0, '0, 5'h1);
        chk("use bti", 1'h0, req_ubti);
        chk("use sampler", 1'h0, req_usmp);
        send(1'h0, SIMD_8, MT_RESINFO, 4'h3, 16'hff, '0, '0, 5'h4);
        chk("use sampler", 1'h0, req_usmp);
        send(1'h0, SIMD_8, MT_SAMPLEINFO, 4'h3, 16'hff, '0, '0, 5'h4);
        chk("use sampler", 1'h0, req_usmp);
        final_report();
    end
endmodule // tb
`default_nettype wire
